// ### bench/cwd_decoder_sva.sv
// Assertion checker for the configuration word decoder, bound to the design.
// Assumes fuse words are steady at the first clock edge after reset release.
`timescale 1ns/100ps

module cwd_decoder_sva (
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic [7:0]  i_source_select_fuse_word,
  input wire logic [7:0]  i_oscillator_fuse_word,
  input wire logic [7:0]  i_watchdog_fuse_word,
  input wire logic [7:0]  i_debug_fuse_word,
  input wire logic        i_source_ready,
  input wire logic        o_config_valid,
  input wire logic        o_start_on_fast_rc,
  input wire logic [2:0]  o_clock_source,
  input wire logic        o_clock_switch_en,
  input wire logic        o_fail_safe_monitor_en,
  input wire logic        o_second_pin_clkout,
  input wire logic        o_second_pin_gpio,
  input wire logic        o_primary_osc_en,
  input wire logic        o_high_speed_crystal_mode,
  input wire logic        o_standard_crystal_mode,
  input wire logic        o_external_clock_mode,
  input wire logic        o_watchdog_run,
  input wire logic        o_low_power_rc_en,
  input wire logic        o_watchdog_window_mode,
  input wire logic [7:0]  o_watchdog_prescale,
  input wire logic [15:0] o_watchdog_postscale,
  input wire logic        o_test_port_enable,
  input wire logic [2:0]  o_debug_pair,
  input wire logic        o_debug_channel_reserved
);
  logic [7:0] src_r;
  logic [7:0] osc_r;
  logic [7:0] wdt_r;
  logic [7:0] dbg_r;

  // Mirror of the one-time capture, so the bench may move the fuse inputs later
  always_ff @(posedge i_core_clk) begin
    if (!o_config_valid) begin
      src_r <= i_source_select_fuse_word;
      osc_r <= i_oscillator_fuse_word;
      wdt_r <= i_watchdog_fuse_word;
      dbg_r <= i_debug_fuse_word;
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_ready_seen;
    o_start_on_fast_rc && i_source_ready;
  endsequence
  sequence s_on_target;
    !o_start_on_fast_rc && o_clock_source == src_r[2:0];
  endsequence

  property p_hold;
    o_config_valid && $past(o_config_valid) |->
      $stable({o_clock_switch_en, o_watchdog_postscale, o_debug_pair, o_primary_osc_en});
  endproperty
  property p_two_speed;
    s_ready_seen |-> ##[1:4] s_on_target;
  endproperty
  property p_fast_src;
    o_start_on_fast_rc |-> o_clock_source == 3'h0 && src_r[7] && src_r[2:0] != 3'h0;
  endproperty
  property p_source;
    o_config_valid && !o_start_on_fast_rc |-> o_clock_source == src_r[2:0];
  endproperty
  property p_switch;
    o_config_valid |-> o_clock_switch_en == !osc_r[7]
      && o_fail_safe_monitor_en == (osc_r[7:6] == 2'h0);
  endproperty
  property p_pin;
    o_config_valid |-> o_second_pin_clkout == (osc_r[2] && !(osc_r[1] ^ osc_r[0]))
      && o_second_pin_gpio == (!osc_r[2] && !(osc_r[1] ^ osc_r[0]));
  endproperty
  property p_primary;
    o_config_valid |-> {o_primary_osc_en, o_high_speed_crystal_mode, o_standard_crystal_mode,
      o_external_clock_mode} == {osc_r[1:0] != 2'h3, osc_r[1:0] == 2'h2,
      osc_r[1:0] == 2'h1, osc_r[1:0] == 2'h0};
  endproperty
  property p_fuse_run;
    o_config_valid && wdt_r[7] |-> o_watchdog_run && o_low_power_rc_en;
  endproperty
  property p_window;
    o_config_valid |-> o_watchdog_window_mode == !wdt_r[6];
  endproperty
  property p_prescale;
    o_config_valid |-> o_watchdog_prescale == (wdt_r[4] ? 8'h80 : 8'h20);
  endproperty
  property p_postscale;
    o_config_valid |-> o_watchdog_postscale == 16'h0001 << wdt_r[3:0];
  endproperty
  property p_test_port;
    o_config_valid |-> o_test_port_enable == dbg_r[5];
  endproperty
  property p_debug;
    o_config_valid |-> {o_debug_pair, o_debug_channel_reserved} == {dbg_r[1:0] == 2'h1,
      dbg_r[1:0] == 2'h2, dbg_r[1:0] == 2'h3, dbg_r[1:0] == 2'h0};
  endproperty

  a_hold: assert property (p_hold) else $error("setting moved");
  a_two_speed: assert property (p_two_speed) else $error("no switch after ready");
  a_fast_src: assert property (p_fast_src) else $error("bad fast start");
  a_source: assert property (p_source) else $error("bad clock source");
  a_switch: assert property (p_switch) else $error("bad switch mode");
  a_pin: assert property (p_pin) else $error("bad pin function");
  a_primary: assert property (p_primary) else $error("bad primary mode");
  a_fuse_run: assert property (p_fuse_run) else $error("watchdog not forced");
  a_window: assert property (p_window) else $error("bad window mode");
  a_prescale: assert property (p_prescale) else $error("bad prescale");
  a_postscale: assert property (p_postscale) else $error("bad postscale");
  a_test_port: assert property (p_test_port) else $error("bad test port");
  a_debug: assert property (p_debug) else $error("bad debug pair");
endmodule

bind cwd_decoder cwd_decoder_sva u_sva (.*);

// ### bench/cwd_decoder_tb_top.sv
// Self-checking bench for the configuration word decoder.
// Assumes one APB master (this bench) and fuse words set while in reset.
`timescale 1ns/100ps

module cwd_decoder_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  src_w = 8'h00;
  logic [7:0]  osc_w = 8'h00;
  logic [7:0]  wdt_w = 8'h00;
  logic [7:0]  dbg_w = 8'h00;
  logic [7:0]  paddr = 8'h00;
  logic        rdy = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic        e;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, valid, fast, swen, mon, clko, gpio, prien, hs, std, ext;
  wire logic        run, low_power_rc_osc, win, tpe, resv;
  wire logic [2:0]  csrc, pair;
  wire logic [7:0]  pre;
  wire logic [15:0] post;
  int n_errors = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  cwd_decoder uut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_source_select_fuse_word(src_w),
    .i_oscillator_fuse_word(osc_w), .i_watchdog_fuse_word(wdt_w), .i_debug_fuse_word(dbg_w),
    .i_source_ready(rdy), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_config_valid(valid), .o_start_on_fast_rc(fast), .o_clock_source(csrc),
    .o_clock_switch_en(swen), .o_fail_safe_monitor_en(mon), .o_second_pin_clkout(clko),
    .o_second_pin_gpio(gpio), .o_primary_osc_en(prien), .o_high_speed_crystal_mode(hs),
    .o_standard_crystal_mode(std), .o_external_clock_mode(ext), .o_watchdog_run(run),
    .o_low_power_rc_en(low_power_rc_osc), .o_watchdog_window_mode(win), .o_watchdog_prescale(pre),
    .o_watchdog_postscale(post), .o_test_port_enable(tpe), .o_debug_pair(pair),
    .o_debug_channel_reserved(resv)
  );

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Fuse words are set here while reset is held, as on real silicon
  task automatic boot(input logic [7:0] s, input logic [7:0] o, input logic [7:0] w,
                      input logic [7:0] d);
    @(posedge clk);
    rst_b <= 1'b0;
    src_w <= s;
    osc_w <= o;
    wdt_w <= w;
    dbg_w <= d;
    repeat (20) @(posedge clk);
    chk("valid in reset", valid, 1'b0);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk("valid after reset", valid, 1'b1);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    chk("ready pulse", pready, 1'b0);
  endtask

  task automatic t_decode;
    logic [3:0] c;
    for (int k = 0; k < 16; k++) begin
      c = k[3:0];
      boot({5'h0, c[2:0]}, {c[1:0], 3'h0, c[2], c[1:0]}, {c[0], c[1], 1'b0, c[2], c},
           {2'h0, c[0], 3'h0, c[1:0]});
      chk("source", csrc, c[2:0]);
      chk("switch", {swen, mon}, {!c[1], c[1:0] == 2'h0});
      chk("pin", {clko, gpio}, (c[1] ^ c[0]) ? 2'h0 : {c[2], !c[2]});
      chk("primary", {prien, hs, std, ext}, {c[1:0] != 2'h3, c[1:0] == 2'h2,
          c[1:0] == 2'h1, c[1:0] == 2'h0});
      chk("watchdog", {run, low_power_rc_osc}, {c[0], c[0] | (c[2:0] == 3'h5)});
      chk("window", win, !c[1]);
      chk("prescale", pre, c[2] ? 8'h80 : 8'h20);
      chk("postscale", post, 16'h0001 << c);
      chk("test port", tpe, c[0]);
      chk("debug", {pair, resv}, {c[1:0] == 2'h1, c[1:0] == 2'h2, c[1:0] == 2'h3,
          c[1:0] == 2'h0});
    end
    $display("test decode done");
  endtask

  task automatic t_soft;
    boot(8'h00, 8'h03, 8'h00, 8'h03);
    apb(1'b1, 8'h00, 32'h1, rd, e);
    chk("soft on", {run, low_power_rc_osc}, 2'h3);
    apb(1'b0, 8'h00, 32'h0, rd, e);
    chk("soft readback", rd, 32'h1);
    apb(1'b1, 8'h00, 32'h0, rd, e);
    chk("soft off", {run, low_power_rc_osc}, 2'h0);
    apb(1'b0, 8'h14, 32'h0, rd, e);
    chk("unmapped error", e, 1'b1);
    apb(1'b1, 8'h08, 32'hffff_ffff, rd, e);
    chk("read only error", e, 1'b0);
    apb(1'b0, 8'h08, 32'h0, rd, e);
    chk("watchdog status", rd, 32'h0001_2008);
    boot(8'h00, 8'h03, 8'h80, 8'h03);
    apb(1'b1, 8'h00, 32'h1, rd, e);
    apb(1'b1, 8'h00, 32'h0, rd, e);
    chk("fuse forced", {run, low_power_rc_osc}, 2'h3);
    $display("test soft enable done");
  endtask

  task automatic t_two_speed;
    int k;
    boot(8'h83, 8'h03, 8'h00, 8'h03);
    repeat (4) @(posedge clk);
    chk("fast start", {fast, csrc}, 4'h8);
    rdy <= 1'b1;
    k = 0;
    while (fast !== 1'b0 && k < 10) begin
      @(posedge clk);
      k++;
    end
    chk("switched", {fast, csrc}, 4'h3);
    chk("switch delay", k <= 5, 1'b1);
    rdy <= 1'b0;
    $display("test two speed done");
  endtask

  task automatic t_hold;
    boot(8'h05, 8'h42, 8'h1b, 8'h22);
    src_w <= 8'hfa;
    osc_w <= 8'hbd;
    wdt_w <= 8'he4;
    dbg_w <= 8'hdd;
    repeat (4) @(posedge clk);
    chk("held source", csrc, 3'h5);
    chk("held postscale", post, 16'h0800);
    apb(1'b0, 8'h10, 32'h0, rd, e);
    chk("raw fuses", rd, 32'h221b_4205);
    apb(1'b0, 8'h04, 32'h0, rd, e);
    chk("clock status", rd, 32'h0000_9885);
    apb(1'b0, 8'h0c, 32'h0, rd, e);
    chk("debug status", rd, 32'h0000_0022);
    $display("test hold done");
  endtask

  initial begin
    t_decode;
    t_soft;
    t_two_speed;
    t_hold;
    complete_run;
  end

  initial begin
    #300000;
    n_errors++;
    $display("watchdog expired");
    complete_run;
  end
endmodule

// ### core/cwd_decoder.sv
// Configuration word decoder: takes the four fuse words at reset release,
// decodes them into clock, watchdog and debug settings, and exposes the
// software watchdog enable and read-back status over an APB slave.
// Assumes fuse words are stable on the core clock around reset release and
// that the source-ready level comes from the oscillator domain.
//
// Function
// - Two-speed start runs fast RC until ready
// - Three-bit initial source field selects the clock
// - Switch/monitor field enables switching and monitor
// - Second pin: clock out or GPIO outside crystals
// - Primary mode: off, HS, standard crystal, external
// - Fuse enable forces watchdog and low-power RC on
// - Otherwise software bit gates watchdog, and RC unless the clock source output is low-power RC (not yet during a two-speed start)
// - Window-disable fuse selects non-window mode
// - Prescale fuse selects divide 128 or 32
// - Postscale field gives ratio two to the code
// - Test port enabled by its fuse
// - Debug channel field picks pin pair, 00 reserved
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "cwd_params.svh"

module cwd_decoder
  import cwd_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_b,
  input  wire logic [`CWD_FUSE_W-1:0] i_source_select_fuse_word,
  input  wire logic [`CWD_FUSE_W-1:0] i_oscillator_fuse_word,
  input  wire logic [`CWD_FUSE_W-1:0] i_watchdog_fuse_word,
  input  wire logic [`CWD_FUSE_W-1:0] i_debug_fuse_word,
  input  wire logic                   i_source_ready,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`CWD_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  output logic                        o_config_valid,
  output logic                        o_start_on_fast_rc,
  output logic      [2:0]             o_clock_source,
  output logic                        o_clock_switch_en,
  output logic                        o_fail_safe_monitor_en,
  output logic                        o_second_pin_clkout,
  output logic                        o_second_pin_gpio,
  output logic                        o_primary_osc_en,
  output logic                        o_high_speed_crystal_mode,
  output logic                        o_standard_crystal_mode,
  output logic                        o_external_clock_mode,
  output logic                        o_watchdog_run,
  output logic                        o_low_power_rc_en,
  output logic                        o_watchdog_window_mode,
  output logic      [7:0]             o_watchdog_prescale,
  output logic      [15:0]            o_watchdog_postscale,
  output logic                        o_test_port_enable,
  output logic      [2:0]             o_debug_pair,
  output logic                        o_debug_channel_reserved
);

  cwd_st_t r;
  cwd_st_t nxt;

  logic [`CWD_SYNC_W-1:0] ready_sync;

  cwd_sync u_ready_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    (i_source_ready),
    .o_sync     (ready_sync)
  );

  // Fields are decoded from the held copy once captured, and straight
  // from the inputs on the capture edge so outputs settle one edge early.
  logic [`CWD_FUSE_W-1:0] src_w;
  logic [`CWD_FUSE_W-1:0] osc_w;
  logic [`CWD_FUSE_W-1:0] wdt_w;
  logic [`CWD_FUSE_W-1:0] dbg_w;
  logic [2:0]             sel_src;
  logic                   two_speed;
  logic [1:0]             pri_mode;
  logic [1:0]             sw_mon;
  logic [3:0]             post_code;
  logic [1:0]             dbg_ch;
  logic                   crystal;
  logic                   fast_family;
  logic                   soft_en_eff;
  logic                   access;
  logic                   complete;
  logic                   mapped;
  logic [31:0]            rd_word;

  always_comb begin
    if (r.state == CWD_CAPTURE) begin
      src_w = i_source_select_fuse_word;
      osc_w = i_oscillator_fuse_word;
      wdt_w = i_watchdog_fuse_word;
      dbg_w = i_debug_fuse_word;
    end else begin
      src_w = r.src_word;
      osc_w = r.osc_word;
      wdt_w = r.wdt_word;
      dbg_w = r.dbg_word;
    end
  end

  assign sel_src   = src_w[`CWD_SRC_SEL_MSB:`CWD_SRC_SEL_LSB];
  assign two_speed = src_w[`CWD_TWO_SPEED_BIT];
  assign pri_mode  = osc_w[`CWD_PRI_MODE_MSB:`CWD_PRI_MODE_LSB];
  assign sw_mon    = osc_w[`CWD_SW_MON_MSB:`CWD_SW_MON_LSB];
  assign post_code = wdt_w[`CWD_POST_MSB:`CWD_POST_LSB];
  assign dbg_ch    = dbg_w[`CWD_DBG_CH_MSB:`CWD_DBG_CH_LSB];

  // Only the fast RC source code itself skips a two-speed start; its PLL and divided variants do not
  assign fast_family = (sel_src == `CWD_SRC_FAST_RC);

  assign crystal = (pri_mode == `CWD_PRI_HS_XTAL) ||
                   (pri_mode == `CWD_PRI_STD_XTAL);

  // APB: one wait state; the write lands on the edge that completes the access
  assign access   = i_psel && i_penable && !r.pready;
  assign complete = i_psel && i_penable && r.pready;

  always_comb begin
    case (i_paddr)
      `CWD_REG_RESET_CTRL,
      `CWD_REG_CLOCK_STAT,
      `CWD_REG_WDT_STAT,
      `CWD_REG_DEBUG_STAT,
      `CWD_REG_FUSE_RAW:   mapped = 1'b1;
      default:             mapped = 1'b0;
    endcase
  end

  // Software enable as seen by the watchdog on the next edge, so a write
  // shows up in the run flag with no extra cycle of lag
  always_comb begin
    soft_en_eff = r.soft_en;
    if (complete && i_pwrite && (i_paddr == `CWD_REG_RESET_CTRL)) begin
      soft_en_eff = i_pwdata[`CWD_SOFT_EN_BIT];
    end
  end

  // Status words are read-only; unused bits read as zero
  always_comb begin
    case (i_paddr)
      `CWD_REG_RESET_CTRL: begin
        rd_word = `CWD_WORD_RST;
        rd_word[`CWD_SOFT_EN_BIT] = r.soft_en;
      end
      `CWD_REG_CLOCK_STAT: begin
        rd_word = {16'h0000,
                   r.valid, r.pri_ext, r.pri_std, r.pri_hs,
                   r.pri_en, r.pin_gpio, r.pin_clkout, r.monitor_en,
                   r.switch_en, r.start_fast, 3'h0,
                   r.clock_source};
      end
      `CWD_REG_WDT_STAT: begin
        rd_word = {r.wdt_post, r.wdt_pre, 4'h0, r.wdt_window,
                   r.low_power_rc_osc_en, r.wdt_run, 1'b0};
      end
      `CWD_REG_DEBUG_STAT: begin
        rd_word = {24'h00_0000, 2'h0, r.test_port_en, r.dbg_reserved,
                   1'b0, r.dbg_pair};
      end
      `CWD_REG_FUSE_RAW: begin
        rd_word = {r.dbg_word, r.wdt_word, r.osc_word, r.src_word};
      end
      default: begin
        rd_word = `CWD_WORD_RST;
      end
    endcase
  end

  always_comb begin
    nxt = r;

    // Capture on the first edge after release, then never again
    if (r.state == CWD_CAPTURE) begin
      nxt.src_word = i_source_select_fuse_word;
      nxt.osc_word = i_oscillator_fuse_word;
      nxt.wdt_word = i_watchdog_fuse_word;
      nxt.dbg_word = i_debug_fuse_word;
    end

    case (r.state)
      CWD_CAPTURE: begin
        if (two_speed && !fast_family) begin
          nxt.state = CWD_FAST_START;
        end else begin
          nxt.state = CWD_RUN;
        end
      end
      CWD_FAST_START: begin
        if (ready_sync[0]) begin
          nxt.state = CWD_RUN;
        end
      end
      CWD_RUN: begin
        nxt.state = CWD_RUN;
      end
      default: begin
        nxt.state = CWD_CAPTURE;
      end
    endcase

    nxt.valid = 1'b1;
    nxt.start_fast = (nxt.state == CWD_FAST_START);
    if (nxt.state == CWD_FAST_START) begin
      nxt.clock_source = `CWD_SRC_FAST_RC;
    end else begin
      nxt.clock_source = sel_src;
    end

    case (sw_mon)
      `CWD_SW_MON_BOTH: begin
        nxt.switch_en  = 1'b1;
        nxt.monitor_en = 1'b1;
      end
      `CWD_SW_MON_SWITCH: begin
        nxt.switch_en  = 1'b1;
        nxt.monitor_en = 1'b0;
      end
      default: begin
        // Upper bit set: both off, whatever the lower bit holds
        nxt.switch_en  = 1'b0;
        nxt.monitor_en = 1'b0;
      end
    endcase

    // In crystal modes the pin belongs to the oscillator
    nxt.pin_clkout = !crystal && osc_w[`CWD_PIN_FUNC_BIT];
    nxt.pin_gpio   = !crystal && !osc_w[`CWD_PIN_FUNC_BIT];

    // Mode flags are one-hot except for the disabled code, which clears them all and drops the enable
    case (pri_mode)
      `CWD_PRI_DISABLED: begin
        nxt.pri_en  = 1'b0;
        nxt.pri_hs  = 1'b0;
        nxt.pri_std = 1'b0;
        nxt.pri_ext = 1'b0;
      end
      `CWD_PRI_HS_XTAL: begin
        nxt.pri_en  = 1'b1;
        nxt.pri_hs  = 1'b1;
        nxt.pri_std = 1'b0;
        nxt.pri_ext = 1'b0;
      end
      `CWD_PRI_STD_XTAL: begin
        nxt.pri_en  = 1'b1;
        nxt.pri_hs  = 1'b0;
        nxt.pri_std = 1'b1;
        nxt.pri_ext = 1'b0;
      end
      default: begin
        nxt.pri_en  = 1'b1;
        nxt.pri_hs  = 1'b0;
        nxt.pri_std = 1'b0;
        nxt.pri_ext = 1'b1;
      end
    endcase

    nxt.soft_en = soft_en_eff;
    if (wdt_w[`CWD_WDT_FUSE_BIT]) begin
      // Soft bit still stores, but cannot stop the watchdog or its clock
      nxt.wdt_run = 1'b1;
      nxt.low_power_rc_osc_en = 1'b1;
    end else begin
      nxt.wdt_run = soft_en_eff;
      nxt.low_power_rc_osc_en = soft_en_eff || (nxt.clock_source == `CWD_SRC_LOW_RC);
    end

    nxt.wdt_window = !wdt_w[`CWD_WIN_DIS_BIT];
    if (wdt_w[`CWD_PRE_BIT]) begin
      nxt.wdt_pre = `CWD_PRE_DIV_HI;
    end else begin
      nxt.wdt_pre = `CWD_PRE_DIV_LO;
    end
    nxt.wdt_post = `CWD_POST_UNIT << post_code;

    nxt.test_port_en = dbg_w[`CWD_TEST_PORT_BIT];

    nxt.dbg_reserved = 1'b0;
    case (dbg_ch)
      `CWD_DBG_PAIR_A: nxt.dbg_pair = 3'h1;
      `CWD_DBG_PAIR_B: nxt.dbg_pair = 3'h2;
      `CWD_DBG_PAIR_C: nxt.dbg_pair = 3'h4;
      default: begin
        // Reserved code: no pair is routed
        nxt.dbg_pair     = 3'h0;
        nxt.dbg_reserved = 1'b1;
      end
    endcase

    nxt.pready  = access;
    nxt.pslverr = access && !mapped;
    if (access && !i_pwrite) begin
      nxt.prdata = rd_word;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r              <= '0;
      r.state        <= CWD_CAPTURE;
      r.src_word     <= `CWD_FUSE_RST;
      r.osc_word     <= `CWD_FUSE_RST;
      r.wdt_word     <= `CWD_FUSE_RST;
      r.dbg_word     <= `CWD_FUSE_RST;
      r.clock_source <= `CWD_SRC_FAST_RC;
      r.wdt_pre      <= `CWD_PRE_DIV_LO;
      r.wdt_post     <= `CWD_POST_UNIT;
      r.prdata       <= `CWD_WORD_RST;
    end else begin
      r <= nxt;
    end
  end

  assign o_prdata                  = r.prdata;
  assign o_pready                  = r.pready;
  assign o_pslverr                 = r.pslverr;
  assign o_config_valid            = r.valid;
  assign o_start_on_fast_rc        = r.start_fast;
  assign o_clock_source            = r.clock_source;
  assign o_clock_switch_en         = r.switch_en;
  assign o_fail_safe_monitor_en    = r.monitor_en;
  assign o_second_pin_clkout       = r.pin_clkout;
  assign o_second_pin_gpio         = r.pin_gpio;
  assign o_primary_osc_en          = r.pri_en;
  assign o_high_speed_crystal_mode = r.pri_hs;
  assign o_standard_crystal_mode   = r.pri_std;
  assign o_external_clock_mode     = r.pri_ext;
  assign o_watchdog_run            = r.wdt_run;
  assign o_low_power_rc_en         = r.low_power_rc_osc_en;
  assign o_watchdog_window_mode    = r.wdt_window;
  assign o_watchdog_prescale       = r.wdt_pre;
  assign o_watchdog_postscale      = r.wdt_post;
  assign o_test_port_enable        = r.test_port_en;
  assign o_debug_pair              = r.dbg_pair;
  assign o_debug_channel_reserved  = r.dbg_reserved;

endmodule

// ### core/cwd_sync.sv
// Two-stage synchroniser for levels arriving from another clock domain.
// Assumes the input is a level that stays put for several clock periods.
`timescale 1ns/100ps
`include "cwd_params.svh"

module cwd_sync
  import cwd_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_b,
  input  wire logic [`CWD_SYNC_W-1:0] i_async,
  output logic      [`CWD_SYNC_W-1:0] o_sync
);

  cwd_sync_st_t r;
  cwd_sync_st_t nxt;

  // Only the second stage is visible; the first may be metastable
  always_comb begin
    nxt.meta   = i_async;
    nxt.stable = r.meta;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign o_sync = r.stable;

endmodule

// ### include/cwd_params.svh
// Constants for the configuration word decoder: fuse field positions,
// field codes, register offsets and reset values.
// Assumes it is included once per compile unit by its bare name.
`ifndef CWD_PARAMS_SVH
`define CWD_PARAMS_SVH

`define CWD_FUSE_W          8
`define CWD_SYNC_W          1
`define CWD_ADDR_W          8

// Source select fuse word
`define CWD_SRC_SEL_LSB     0
`define CWD_SRC_SEL_MSB     2
`define CWD_TWO_SPEED_BIT   7
// Oscillator fuse word
`define CWD_PRI_MODE_LSB    0
`define CWD_PRI_MODE_MSB    1
`define CWD_PIN_FUNC_BIT    2
`define CWD_SW_MON_LSB      6
`define CWD_SW_MON_MSB      7
// Watchdog fuse word
`define CWD_POST_LSB        0
`define CWD_POST_MSB        3
`define CWD_PRE_BIT         4
`define CWD_WIN_DIS_BIT     6
`define CWD_WDT_FUSE_BIT    7
// Debug fuse word
`define CWD_DBG_CH_LSB      0
`define CWD_DBG_CH_MSB      1
`define CWD_TEST_PORT_BIT   5

// Initial source codes
`define CWD_SRC_FAST_RC     3'h0
`define CWD_SRC_FAST_PLL    3'h1
`define CWD_SRC_PRI         3'h2
`define CWD_SRC_PRI_PLL     3'h3
`define CWD_SRC_SECONDARY   3'h4
`define CWD_SRC_LOW_RC      3'h5
`define CWD_SRC_FAST_DIV16  3'h6
`define CWD_SRC_FAST_POST   3'h7

// Primary oscillator mode codes
`define CWD_PRI_EXT_CLOCK   2'h0
`define CWD_PRI_STD_XTAL    2'h1
`define CWD_PRI_HS_XTAL     2'h2
`define CWD_PRI_DISABLED    2'h3

// Switch and monitor codes
`define CWD_SW_MON_BOTH     2'h0
`define CWD_SW_MON_SWITCH   2'h1

// Debug channel codes
`define CWD_DBG_PAIR_A      2'h3
`define CWD_DBG_PAIR_B      2'h2
`define CWD_DBG_PAIR_C      2'h1

// Watchdog dividers
`define CWD_PRE_DIV_HI      8'h80
`define CWD_PRE_DIV_LO      8'h20
`define CWD_POST_UNIT       16'h0001

// Register byte offsets and the soft enable bit
`define CWD_REG_RESET_CTRL  8'h00
`define CWD_REG_CLOCK_STAT  8'h04
`define CWD_REG_WDT_STAT    8'h08
`define CWD_REG_DEBUG_STAT  8'h0c
`define CWD_REG_FUSE_RAW    8'h10
`define CWD_SOFT_EN_BIT     0

`define CWD_FUSE_RST        8'h00
`define CWD_WORD_RST        32'h0000_0000

`endif

// ### include/cwd_pkg.sv
// Types for the configuration word decoder.
// Assumes cwd_params.svh is on the include path.
`include "cwd_params.svh"

package cwd_pkg;

  typedef enum logic [1:0] {
    CWD_CAPTURE,
    CWD_FAST_START,
    CWD_RUN
  } cwd_state_t;

  typedef struct packed {
    logic [`CWD_SYNC_W-1:0] meta;
    logic [`CWD_SYNC_W-1:0] stable;
  } cwd_sync_st_t;

  typedef struct packed {
    cwd_state_t             state;
    logic [`CWD_FUSE_W-1:0] src_word;
    logic [`CWD_FUSE_W-1:0] osc_word;
    logic [`CWD_FUSE_W-1:0] wdt_word;
    logic [`CWD_FUSE_W-1:0] dbg_word;
    logic                   soft_en;
    logic                   valid;
    logic                   start_fast;
    logic [2:0]             clock_source;
    logic                   switch_en;
    logic                   monitor_en;
    logic                   pin_clkout;
    logic                   pin_gpio;
    logic                   pri_en;
    logic                   pri_hs;
    logic                   pri_std;
    logic                   pri_ext;
    logic                   wdt_run;
    logic                   low_power_rc_osc_en;
    logic                   wdt_window;
    logic [7:0]             wdt_pre;
    logic [15:0]            wdt_post;
    logic                   test_port_en;
    logic [2:0]             dbg_pair;
    logic                   dbg_reserved;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
  } cwd_st_t;

endpackage
